// ---- core/cgtl_core.sv ----
// Command gear scaling and torque limit register block with APB access.
// How it works
// - torque limits range 0..300, default 300.
// - some pairings use another bound instead.
// - one bound covers all five torque settings.
// - rpm equals frequency times ratio over ppr times 60.
// - gear numerator and denominator accept 1..2^30.
// - excessive multiplication with a noisy pulse raises pulse multiply error.
// - power-cycle settings apply only after restart.
// - control register holds one of four control modes.
module cgtl_core
#(
  parameter int FREQ_W = 24,  // Width of the measured pulse rate.
  parameter int ENC_W = 24,  // Width of encoder pulses per turn.
  parameter logic [31:0] OVF_LIMIT = 32'h0000_03E8  // Ratio for the error.
)
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,  // Clock enable; low freezes all state.
  input wire logic power_restart_i,  // Pulse: supply was cycled.
  input wire logic [9:0] pairing_bound_i,  // Bound of the fitted pairing.
  input wire logic [FREQ_W-1:0] pulse_freq_i,  // Command pulse rate.
  input wire logic pulse_glitch_i,  // Pulse: noisy or irregular edge seen.
  input wire logic [ENC_W-1:0] enc_ppr_i,  // Encoder pulses per turn.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output cgtl_pkg::cgtl_torque_t torque_o,
  output cgtl_pkg::cgtl_gear_t gear_o,
  output cgtl_pkg::cgtl_mode_t mode_o,
  output logic [31:0] speed_rpm_o,
  output logic pulse_multiply_error_o
);

  // Elaboration stops on widths that the 32-bit bus cannot carry.
  if (FREQ_W < 1 || FREQ_W > 32 || ENC_W < 1 || ENC_W > 32)
  begin : g_width_check
    $error("cgtl_core: width parameters out of range");
  end

  // All checks of this module use this clock and this reset.
  default clocking cgtl_chk_cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Clamps a torque write to the active bound.
  function automatic logic [9:0] clamp_trq(input logic [31:0] v,
                                           input logic [9:0] b);
    clamp_trq = (v > {22'h00_0000, b}) ? b : v[9:0];
  endfunction : clamp_trq

  // Forces a gear value into 1..2^30.
  function automatic logic [30:0] clamp_gear(input logic [31:0] v);
    logic [30:0] r;
    r = v[30:0];
    if (v == 32'h0000_0000)
    begin
      r = cgtl_pkg::GEAR_MIN;
    end
    else if (v > {1'b0, cgtl_pkg::GEAR_MAX})
    begin
      r = cgtl_pkg::GEAR_MAX;
    end
    clamp_gear = r;
  endfunction : clamp_gear

  ////////////////////////////////////////////////////////////////////////////
  // State.

  cgtl_pkg::cgtl_torque_t trq_reg;  // Live torque settings.
  cgtl_pkg::cgtl_torque_t trq_next;
  cgtl_pkg::cgtl_gear_t stage_reg;  // Gear values awaiting power cycle.
  cgtl_pkg::cgtl_gear_t stage_next;
  cgtl_pkg::cgtl_gear_t gear_reg;  // Gear values in use.
  cgtl_pkg::cgtl_gear_t gear_next;
  cgtl_pkg::cgtl_mode_t mode_reg;
  cgtl_pkg::cgtl_mode_t mode_next;
  logic [9:0] bound_reg;  // Bound latched at power-up.
  logic [9:0] bound_next;
  logic err_reg;  // Sticky pulse multiply error.
  logic err_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic slverr_reg;
  logic slverr_next;
  logic bound_valid_reg;  // Bound captured after reset release.
  logic bound_valid_next;
  logic setup;
  logic wr;
  logic hit;
  logic over;
  logic [31:0] rpm;

  // Setup-phase capture gives a zero-wait-state slave.
  assign setup = ce_i && psel_i && !penable_i;
  assign wr = psel_i && penable_i && pwrite_i && pready_o && ce_i;
  assign pready_o = 1'b1;
  assign prdata_o = rdata_reg;
  assign pslverr_o = slverr_reg;

  // Ratio above the limit: numerator greater than limit times denominator.
  assign over = {32'h0000_0000, gear_reg.gear_numerator} >
                (63'(OVF_LIMIT) * {32'h0000_0000, gear_reg.gear_denominator});

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for registers, bus reads and the error flag.
  always_comb
  begin
    trq_next = trq_reg;
    stage_next = stage_reg;
    gear_next = gear_reg;
    mode_next = mode_reg;
    bound_next = bound_reg;
    bound_valid_next = 1'b1;
    err_next = err_reg;
    rdata_next = rdata_reg;
    slverr_next = 1'b0;
    hit = 1'b1;
    // The pairing bound is a strap taken once after reset or power cycle.
    if (!bound_valid_reg || power_restart_i)
    begin
      bound_next = (pairing_bound_i == 10'h000) ? cgtl_pkg::TRQ_DEFAULT
                                               : pairing_bound_i;
    end
    // A power cycle moves staged gear values into use.
    if (power_restart_i)
    begin
      gear_next = stage_reg;
    end
    unique case (paddr_i)
      cgtl_pkg::OFS_TRQ1, cgtl_pkg::OFS_TRQ2, cgtl_pkg::OFS_ESTOP,
      cgtl_pkg::OFS_EXTP, cgtl_pkg::OFS_EXTN, cgtl_pkg::OFS_NUM,
      cgtl_pkg::OFS_DEN, cgtl_pkg::OFS_BOUND, cgtl_pkg::OFS_CTRL,
      cgtl_pkg::OFS_STAT, cgtl_pkg::OFS_SPEED, cgtl_pkg::OFS_NUMA,
      cgtl_pkg::OFS_DENA: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    if (wr)
    begin
      unique case (paddr_i)
        cgtl_pkg::OFS_TRQ1: trq_next.first_torque_limit =
          clamp_trq(pwdata_i, bound_reg);
        cgtl_pkg::OFS_TRQ2: trq_next.second_torque_limit =
          clamp_trq(pwdata_i, bound_reg);
        cgtl_pkg::OFS_ESTOP: trq_next.emergency_stop_torque =
          clamp_trq(pwdata_i, bound_reg);
        cgtl_pkg::OFS_EXTP: trq_next.ext_positive_torque_limit =
          clamp_trq(pwdata_i, bound_reg);
        cgtl_pkg::OFS_EXTN: trq_next.ext_negative_torque_limit =
          clamp_trq(pwdata_i, bound_reg);
        cgtl_pkg::OFS_NUM: stage_next.gear_numerator = clamp_gear(pwdata_i);
        cgtl_pkg::OFS_DEN: stage_next.gear_denominator =
          clamp_gear(pwdata_i);
        cgtl_pkg::OFS_CTRL:
        begin
          mode_next = cgtl_pkg::cgtl_mode_t'(
            pwdata_i[cgtl_pkg::CTRL_MODE_LSB +: 2]);
          if (pwdata_i[cgtl_pkg::CTRL_CLR_BIT])
          begin
            err_next = 1'b0;
          end
        end
        default: slverr_next = !hit;
      endcase
    end
    // The error sets on a glitch under an excessive ratio; set beats clear.
    if (ce_i && over && pulse_glitch_i)
    begin
      err_next = 1'b1;
    end
    // A newly latched bound also trims stored settings to fit it, so a
    // smaller pairing never leaves a limit above what the motor allows.
    if (bound_next != bound_reg)
    begin
      trq_next.first_torque_limit =
        clamp_trq(32'(trq_next.first_torque_limit), bound_next);
      trq_next.second_torque_limit =
        clamp_trq(32'(trq_next.second_torque_limit), bound_next);
      trq_next.emergency_stop_torque =
        clamp_trq(32'(trq_next.emergency_stop_torque), bound_next);
      trq_next.ext_positive_torque_limit =
        clamp_trq(32'(trq_next.ext_positive_torque_limit), bound_next);
      trq_next.ext_negative_torque_limit =
        clamp_trq(32'(trq_next.ext_negative_torque_limit), bound_next);
    end
    if (setup)
    begin
      slverr_next = !hit;
      unique case (paddr_i)
        cgtl_pkg::OFS_TRQ1: rdata_next = 32'(trq_reg.first_torque_limit);
        cgtl_pkg::OFS_TRQ2: rdata_next = 32'(trq_reg.second_torque_limit);
        cgtl_pkg::OFS_ESTOP: rdata_next = 32'(trq_reg.emergency_stop_torque);
        cgtl_pkg::OFS_EXTP:
          rdata_next = 32'(trq_reg.ext_positive_torque_limit);
        cgtl_pkg::OFS_EXTN:
          rdata_next = 32'(trq_reg.ext_negative_torque_limit);
        cgtl_pkg::OFS_NUM: rdata_next = 32'(stage_reg.gear_numerator);
        cgtl_pkg::OFS_DEN: rdata_next = 32'(stage_reg.gear_denominator);
        cgtl_pkg::OFS_BOUND: rdata_next = 32'(bound_reg);
        cgtl_pkg::OFS_CTRL: rdata_next = 32'(mode_reg);
        cgtl_pkg::OFS_STAT: rdata_next = 32'(err_reg);
        cgtl_pkg::OFS_SPEED: rdata_next = rpm;
        cgtl_pkg::OFS_NUMA: rdata_next = 32'(gear_reg.gear_numerator);
        cgtl_pkg::OFS_DENA: rdata_next = 32'(gear_reg.gear_denominator);
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registering. Reset loads defaults of 300 and a ratio of one.
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      trq_reg <= {5{cgtl_pkg::TRQ_DEFAULT}};
      stage_reg <= {cgtl_pkg::GEAR_MIN, cgtl_pkg::GEAR_MIN};
      gear_reg <= {cgtl_pkg::GEAR_MIN, cgtl_pkg::GEAR_MIN};
      mode_reg <= cgtl_pkg::CGTL_MODE_POS;
      bound_reg <= cgtl_pkg::TRQ_DEFAULT;
      bound_valid_reg <= 1'b0;
      err_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      slverr_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      trq_reg <= trq_next;
      stage_reg <= stage_next;
      gear_reg <= gear_next;
      mode_reg <= mode_next;
      bound_reg <= bound_next;
      bound_valid_reg <= bound_valid_next;
      err_reg <= err_next;
      rdata_reg <= rdata_next;
      slverr_reg <= slverr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Speed calculation.
  cgtl_speed #(.FREQ_W(FREQ_W), .ENC_W(ENC_W)) u_speed
  (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .en_i(ce_i),
    .freq_i(pulse_freq_i),
    .gear_i(gear_reg),
    .enc_ppr_i(enc_ppr_i),
    .rpm_o(rpm)
  );

  assign torque_o = trq_reg;
  assign gear_o = gear_reg;
  assign mode_o = mode_reg;
  assign speed_rpm_o = rpm;
  assign pulse_multiply_error_o = err_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks. They use the default clock and reset declared at the top.

  // Every one of the five stored settings stays within the active bound.
  a_trq_bound: assert property (
    trq_reg.first_torque_limit <= bound_reg &&
    trq_reg.second_torque_limit <= bound_reg &&
    trq_reg.emergency_stop_torque <= bound_reg &&
    trq_reg.ext_positive_torque_limit <= bound_reg &&
    trq_reg.ext_negative_torque_limit <= bound_reg)
    else $error("torque setting above bound");
  // Both applied gear values stay between one and two to the 30th.
  a_gear_range: assert property (
    gear_reg.gear_numerator >= cgtl_pkg::GEAR_MIN &&
    gear_reg.gear_numerator <= cgtl_pkg::GEAR_MAX &&
    gear_reg.gear_denominator >= cgtl_pkg::GEAR_MIN &&
    gear_reg.gear_denominator <= cgtl_pkg::GEAR_MAX)
    else $error("gear value out of range");
  a_gear_hold: assert property (
    !$past(power_restart_i) |-> $stable(gear_reg))
    else $error("gear changed without power cycle");
  a_err_set: assert property (
    ce_i && over && pulse_glitch_i |=> err_reg)
    else $error("multiply error not raised");
  a_err_cause: assert property (
    $rose(err_reg) |-> $past(over && pulse_glitch_i))
    else $error("multiply error without cause");
  // The bound must not move at the same edge, or the trim would win.
  a_trq_clamp: assert property (
    wr && paddr_i == cgtl_pkg::OFS_TRQ1 && pwdata_i > 32'(bound_reg)
    && !power_restart_i && bound_valid_reg
    |=> trq_reg.first_torque_limit == $past(bound_reg))
    else $error("torque write not clamped");
  a_bound_dflt: assert property (
    bound_valid_reg && ce_i && $past(ce_i) && $past(power_restart_i) &&
    $past(pairing_bound_i) == 10'h000 |-> bound_reg == cgtl_pkg::TRQ_DEFAULT)
    else $error("default bound not 300");
  a_mode_write: assert property (
    wr && paddr_i == cgtl_pkg::OFS_CTRL |=>
    mode_reg == $past(pwdata_i[1:0]))
    else $error("mode not written");
  c_err: cover property ($rose(err_reg));
  c_restart: cover property (power_restart_i && ce_i);
  c_clamp: cover property (wr && pwdata_i > 32'(bound_reg));
  c_frozen: cover property (!ce_i && psel_i);

endmodule : cgtl_core

// ---- core/cgtl_pkg.sv ----
// Package of constants and types for the command gear and torque limit block.
package cgtl_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] OFS_TRQ1 = 8'h00;  // First torque limit.
  localparam logic [7:0] OFS_TRQ2 = 8'h04;  // Second torque limit.
  localparam logic [7:0] OFS_ESTOP = 8'h08;  // Emergency-stop torque.
  localparam logic [7:0] OFS_EXTP = 8'h0C;  // External positive limit.
  localparam logic [7:0] OFS_EXTN = 8'h10;  // External negative limit.
  localparam logic [7:0] OFS_NUM = 8'h14;  // Gear numerator (staged).
  localparam logic [7:0] OFS_DEN = 8'h18;  // Gear denominator (staged).
  localparam logic [7:0] OFS_BOUND = 8'h1C;  // Torque bound of the pairing.
  localparam logic [7:0] OFS_CTRL = 8'h20;  // Control: mode, error clear.
  localparam logic [7:0] OFS_STAT = 8'h24;  // Status: error flag.
  localparam logic [7:0] OFS_SPEED = 8'h28;  // Computed speed in rpm.
  localparam logic [7:0] OFS_NUMA = 8'h2C;  // Applied numerator.
  localparam logic [7:0] OFS_DENA = 8'h30;  // Applied denominator.

  // Torque figures in percent of rated torque.
  localparam logic [9:0] TRQ_DEFAULT = 10'h12C;  // 300.
  localparam logic [9:0] TRQ_SMALL = 10'h15E;  // 350, small frames.
  localparam logic [9:0] TRQ_MID = 10'h108;  // 264, one mid pairing.

  // Gear range and speed conversion figures.
  localparam logic [30:0] GEAR_MIN = 31'h0000_0001;
  localparam logic [30:0] GEAR_MAX = 31'h4000_0000;  // Two to the 30th.
  localparam logic [7:0] SEC_PER_MIN = 8'h3C;  // 60.

  // Control register field positions.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_CLR_BIT = 4;

  // Control modes that a parameter may belong to.
  typedef enum logic [1:0]
  {
    CGTL_MODE_POS = 2'b00,
    CGTL_MODE_VEL = 2'b01,
    CGTL_MODE_TRQ = 2'b10,
    CGTL_MODE_FULL = 2'b11
  } cgtl_mode_t;

  // The five bounded torque settings travel together.
  typedef struct packed
  {
    logic [9:0] first_torque_limit;
    logic [9:0] second_torque_limit;
    logic [9:0] emergency_stop_torque;
    logic [9:0] ext_positive_torque_limit;
    logic [9:0] ext_negative_torque_limit;
  } cgtl_torque_t;

  // Electronic gear pair, used for both the staged and the applied values.
  typedef struct packed
  {
    logic [30:0] gear_numerator;
    logic [30:0] gear_denominator;
  } cgtl_gear_t;

endpackage : cgtl_pkg

// ---- core/cgtl_speed.sv ----
// Pipelined speed calculation from pulse rate and gear ratio.
module cgtl_speed
#(
  parameter int FREQ_W = 24,
  parameter int ENC_W = 24
)
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic en_i,
  input wire logic [FREQ_W-1:0] freq_i,
  input wire cgtl_pkg::cgtl_gear_t gear_i,
  input wire logic [ENC_W-1:0] enc_ppr_i,
  output logic [31:0] rpm_o
);

  // Product widths; the quotient is kept wide and saturated at the end.
  localparam int PW = FREQ_W + 31 + 8;

  logic [PW-1:0] prod_reg;  // Frequency times numerator times 60.
  logic [PW-1:0] prod_next;
  logic [PW-1:0] div_reg;  // Denominator times encoder pulses.
  logic [PW-1:0] div_next;
  logic [31:0] rpm_reg;
  logic [31:0] rpm_next;
  logic [PW-1:0] quot;

  // Two-stage arithmetic. A true divider is costly; this is a reference
  // form that a later timing pass may replace with an iterative one.
  always_comb
  begin
    prod_next = PW'(freq_i) * PW'(gear_i.gear_numerator)
      * PW'(cgtl_pkg::SEC_PER_MIN);
    div_next = PW'(gear_i.gear_denominator) * PW'(enc_ppr_i);
    quot = (div_reg == '0) ? '0 : prod_reg / div_reg;
    rpm_next = (quot > PW'(32'hFFFF_FFFF)) ? 32'hFFFF_FFFF : quot[31:0];
  end

  // Registers only update while the enable is high.
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      prod_reg <= '0;
      div_reg <= '0;
      rpm_reg <= '0;
    end
    else if (en_i)
    begin
      prod_reg <= prod_next;
      div_reg <= div_next;
      rpm_reg <= rpm_next;
    end
  end

  assign rpm_o = rpm_reg;

endmodule : cgtl_speed

// ---- dv/cgtl_host.sv ----
// Model of the host controller that feeds command pulses to the block.
module cgtl_host
(
  input wire logic clk_i,
  output logic [23:0] freq_o,
  output logic glitch_o
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  // Idle host: no pulses and a clean line at time zero.
  initial
  begin
    freq_o = 24'h00_0000;
    glitch_o = 1'b0;
  end

  // A new rate is launched right after an edge and then held as a level.
  task set_rate(input logic [23:0] rate);
    @(posedge clk_i);
    freq_o <= rate;
  endtask : set_rate

  // One irregular edge, a single-cycle pulse, as noise on the line would give.
  task noise();
    @(posedge clk_i);
    glitch_o <= 1'b1;
    @(posedge clk_i);
    glitch_o <= 1'b0;
  endtask : noise

endmodule : cgtl_host

// ---- dv/command_gear_torque_limit_test.sv ----
// Self-checking bench of the gear scaling and torque limit register block.
module command_gear_torque_limit_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic power_restart_i = 1'b0;
  logic ce_i = 1'b1;  // Clock enable, lowered once to see a freeze.
  logic [9:0] pairing_bound_i = 10'h000;
  logic [23:0] pulse_freq;
  logic pulse_glitch;
  logic [23:0] enc_ppr_i = 24'h80_0000;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  cgtl_pkg::cgtl_torque_t torque_o;
  cgtl_pkg::cgtl_gear_t gear_o;
  cgtl_pkg::cgtl_mode_t mode_o;
  logic [31:0] speed_rpm_o;
  logic pulse_multiply_error_o;
  int fail_count = 0;  // Mismatches seen.
  int checks_done = 0;  // Comparisons made.
  logic [31:0] d;  // Last read data.
  logic err;  // Last error response.
  logic [7:0] trq_ofs [5] = '{cgtl_pkg::OFS_TRQ1, cgtl_pkg::OFS_TRQ2,
    cgtl_pkg::OFS_ESTOP, cgtl_pkg::OFS_EXTP, cgtl_pkg::OFS_EXTN};

  // Free-running 100 MHz clock.
  always #5 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////
  // Every input is driven, the clock enable too, so a freeze is seen.
  cgtl_core dut
  (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
    .power_restart_i(power_restart_i), .pairing_bound_i(pairing_bound_i),
    .pulse_freq_i(pulse_freq), .pulse_glitch_i(pulse_glitch),
    .enc_ppr_i(enc_ppr_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .torque_o(torque_o), .gear_o(gear_o), .mode_o(mode_o),
    .speed_rpm_o(speed_rpm_o),
    .pulse_multiply_error_o(pulse_multiply_error_o)
  );

  cgtl_host host
  (
    .clk_i(clk_i),
    .freq_o(pulse_freq),
    .glitch_o(pulse_glitch)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Counts and reports one comparison; case inequality keeps X from passing.
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // One APB transfer; the request is held until pready is seen at an edge.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    d = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask : wr

  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  // Models a supply cycle: staged gear applies and the bound is re-taken.
  task restart();
    @(posedge clk_i);
    power_restart_i <= 1'b1;
    @(posedge clk_i);
    power_restart_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : restart

  // The one place where the run ends.
  task summarize();
    if (fail_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: the tests need a few hundred cycles, so this is ample.
  initial
  begin
    #200000;
    fail_count++;
    summarize();
  end

  // Main sequence.
  initial
  begin
    repeat (10) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    // Reset values of the five limits and the applied gear.
    foreach (trq_ofs[i])
    begin
      rd(trq_ofs[i]);
      chk("torque reset", d, 32'h0000_012C);
    end
    rd(cgtl_pkg::OFS_NUMA);
    chk("num reset", d, 32'h0000_0001);
    rd(cgtl_pkg::OFS_DENA);
    chk("den reset", d, 32'h0000_0001);
    // Range ends with no pairing bound: 301 clamps, 0 is kept.
    wr(cgtl_pkg::OFS_TRQ1, 32'h0000_012D);
    rd(cgtl_pkg::OFS_TRQ1);
    chk("torque clamp", d, 32'h0000_012C);
    wr(cgtl_pkg::OFS_TRQ1, 32'h0000_0000);
    rd(cgtl_pkg::OFS_TRQ1);
    chk("torque zero", d, 32'h0000_0000);
    // Small-frame pairing with bound 350 for all five settings.
    pairing_bound_i <= 10'h15E;
    restart();
    rd(cgtl_pkg::OFS_BOUND);
    chk("bound 350", d, 32'h0000_015E);
    foreach (trq_ofs[i])
    begin
      wr(trq_ofs[i], 32'h0000_015F);
      rd(trq_ofs[i]);
      chk("torque 350", d, 32'h0000_015E);
    end
    // Changing to the 264 pairing trims what is stored.
    pairing_bound_i <= 10'h108;
    restart();
    foreach (trq_ofs[i])
    begin
      rd(trq_ofs[i]);
      chk("torque 264", d, 32'h0000_0108);
    end
    chk("ext neg out", {22'h0, torque_o.ext_negative_torque_limit},
      32'h0000_0108);
    wr(cgtl_pkg::OFS_BOUND, 32'h0000_0000);
    rd(cgtl_pkg::OFS_BOUND);
    chk("bound ro", d, 32'h0000_0108);
    // Gear ends out of range; nothing applies before the supply cycle.
    wr(cgtl_pkg::OFS_NUM, 32'h0000_0000);
    wr(cgtl_pkg::OFS_DEN, 32'h4000_0001);
    rd(cgtl_pkg::OFS_DENA);
    chk("den staged", d, 32'h0000_0001);
    restart();
    rd(cgtl_pkg::OFS_NUMA);
    chk("num min", d, 32'h0000_0001);
    rd(cgtl_pkg::OFS_DENA);
    chk("den max", d, 32'h4000_0000);
    // 500 kpps, 8388608/15000 on a 2^23 encoder gives 2000 rpm.
    wr(cgtl_pkg::OFS_NUM, 32'h0080_0000);
    wr(cgtl_pkg::OFS_DEN, 32'h0000_3A98);
    restart();
    chk("num out", 32'(gear_o.gear_numerator), 32'h0080_0000);
    chk("den out", 32'(gear_o.gear_denominator), 32'h0000_3A98);
    host.set_rate(24'h07_A120);
    repeat (4) @(posedge clk_i);
    rd(cgtl_pkg::OFS_SPEED);
    chk("speed reg", d, 32'h0000_07D0);
    chk("speed out", speed_rpm_o, 32'h0000_07D0);
    // Noise at ratio 1000 is tolerated, at 1001 it trips the error.
    wr(cgtl_pkg::OFS_NUM, 32'h0000_03E8);
    wr(cgtl_pkg::OFS_DEN, 32'h0000_0001);
    restart();
    host.noise();
    rd(cgtl_pkg::OFS_STAT);
    chk("no error", d, 32'h0000_0000);
    wr(cgtl_pkg::OFS_NUM, 32'h0000_03E9);
    restart();
    host.noise();
    rd(cgtl_pkg::OFS_STAT);
    chk("error set", d, 32'h0000_0001);
    chk("error out", {31'h0, pulse_multiply_error_o}, 32'h0000_0001);
    wr(cgtl_pkg::OFS_CTRL, 32'h0000_0010);
    rd(cgtl_pkg::OFS_STAT);
    chk("error clear", d, 32'h0000_0000);
    // Every control mode is written and read back.
    for (int m = 0; m < 4; m++)
    begin
      wr(cgtl_pkg::OFS_CTRL, 32'(m));
      rd(cgtl_pkg::OFS_CTRL);
      chk("mode reg", d, 32'(m));
      chk("mode out", {30'h0, mode_o}, 32'(m));
    end
    // Unmapped address answers with an error and reads zero.
    wr(8'h40, 32'hFFFF_FFFF);
    chk("unmapped wr", {31'h0, err}, 32'h0000_0001);
    rd(8'h40);
    chk("unmapped rd", d, 32'h0000_0000);
    chk("unmapped rd err", {31'h0, err}, 32'h0000_0001);
    // With the clock enable low a write is not taken at all.
    @(posedge clk_i);
    ce_i <= 1'b0;
    wr(cgtl_pkg::OFS_TRQ2, 32'h0000_0005);
    ce_i <= 1'b1;
    rd(cgtl_pkg::OFS_TRQ2);
    chk("frozen write", d, 32'h0000_0108);
    // A strap of zero selects the default bound of 300 again.
    pairing_bound_i <= 10'h000;
    restart();
    rd(cgtl_pkg::OFS_BOUND);
    chk("bound dflt", d, 32'h0000_012C);
    summarize();
  end

endmodule : command_gear_torque_limit_test
